// ===== ltdc_pkg.sv
// constants and types for the link training debug controls
// Operation
// - set lane start-data-stream flag at 8G
// - flag stays set until one written
// - self-link bit makes training link itself
// - bypass treats all receivers present
// - inhibit treats all receivers absent
// - bypass wins over inhibit
// - both clear: use real detection result
// - force mid-rate emphasis except Polling.Compliance
// - level bit: zero -6dB, one -3.5dB
// - margin per protocol or forced value
// - slow scrambling off in Configuration.Complete
// - select bit chooses alignment hint source
// - exclusion bits drop states from low hint
// - cfg complete low only after rx criteria
// - rec rcvr cfg low only after rx criteria
package ltdc_pkg;
  localparam int LANES = 16;
  localparam logic [7:0] OFF_SELF_LINK = 8'hC0;
  localparam logic [7:0] OFF_RX_DET = 8'hC4;
  localparam logic [7:0] OFF_TX_FORCE = 8'hC8;
  localparam logic [7:0] OFF_SLOW_SCR = 8'hCC;
  localparam logic [7:0] OFF_FAST_SCR = 8'hD0;
  localparam logic [7:0] OFF_BALIGN = 8'hD4;
  localparam logic [7:0] OFF_SDS_FLAGS = 8'hD8;
  localparam int B_EN = 0;
  localparam int B_BYPASS = 0;
  localparam int B_INHIBIT = 16;
  localparam int B_EMPH_ON = 9;
  localparam int B_EMPH_LVL = 8;
  localparam int B_MARGIN_EN = 3;
  localparam int B_MARGIN_HI = 2;
  localparam int B_ALG_SEL = 31;
  localparam int B_EXCL_HI = 5;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  localparam logic [1:0] RATE_2G5 = 2'h0;
  localparam logic [1:0] RATE_5G = 2'h1;
  localparam logic [1:0] RATE_8G = 2'h2;
  localparam logic [1:0] RATE_16G = 2'h3;
  // excluded-state index in the skip mask
  localparam int X_L0 = 0;
  localparam int X_REC_IDLE = 1;
  localparam int X_REC_RCVR_CFG = 2;
  localparam int X_CFG_IDLE = 3;
  localparam int X_CFG_COMPLETE = 4;
  localparam int X_LPBK_LEADER = 5;
  typedef enum logic [3:0] {
    LTDC_ST_DETECT, LTDC_ST_POLL_ACTIVE, LTDC_ST_POLL_COMPLIANCE, LTDC_ST_CFG_LINK,
    LTDC_ST_CFG_COMPLETE, LTDC_ST_CFG_IDLE, LTDC_ST_L0, LTDC_ST_TX_L0S,
    LTDC_ST_REC_LOCK, LTDC_ST_REC_RCVR_CFG, LTDC_ST_REC_IDLE, LTDC_ST_LPBK_LEADER,
    LTDC_ST_OTHER
  } ltdc_ltssm_t;
endpackage

// ===== ltdc_ctl_if.sv
// control bundle between register bank and phy-side logic
`timescale 1ns/1ps
interface ltdc_ctl_if;
  logic self_link;
  logic rxdet_bypass;
  logic rxdet_inhibit;
  logic emph_on;
  logic emph_level;
  logic margin_en;
  logic [2:0] margin_val;
  logic slow_scr_off;
  logic fast_scr_off;
  logic alg_sel;
  logic [5:0] skip_mask;
  modport regs (output self_link, rxdet_bypass, rxdet_inhibit, emph_on, emph_level,
    margin_en, margin_val, slow_scr_off, fast_scr_off, alg_sel, skip_mask);
  modport phy (input self_link, rxdet_bypass, rxdet_inhibit, emph_on, emph_level,
    margin_en, margin_val, slow_scr_off, fast_scr_off, alg_sel, skip_mask);
endinterface

// ===== ltdc_sds_flags.sv
// sticky per-lane start-of-data-stream flags
`timescale 1ns/1ps
module ltdc_sds_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ltdc_pkg::LANES-1:0] sds_seen,
  input wire logic [1:0] rate,
  input wire logic clr_stb,
  input wire logic [ltdc_pkg::LANES-1:0] clr_bits,
  output logic [ltdc_pkg::LANES-1:0] flags_r
);
  wire at_fast = (rate == ltdc_pkg::RATE_8G);
  genvar i;
  generate
    for (i = 0; i < ltdc_pkg::LANES; i++) begin : g_lane
      wire set_i = sds_seen[i] & at_fast;
      wire clr_i = clr_stb & clr_bits[i];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_r[i] <= 1'b0;
        end else if (set_i) begin
          flags_r[i] <= 1'b1;
        end else if (clr_i) begin
          flags_r[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// ===== ltdc_regs.sv
// apb register bank for link training debug controls
`timescale 1ns/1ps
module ltdc_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [ltdc_pkg::LANES-1:0] sds_flags,
  output logic [31:0] prdata_r,
  output logic pslverr_r,
  output logic sds_clr_stb,
  ltdc_ctl_if.regs ctl
);
  logic self_r, byp_r, inh_r, emph_on_r, emph_lvl_r, marg_en_r, slow_r, fast_r, alg_r;
  logic [2:0] marg_val_r;
  logic [5:0] skip_r;
  wire setup = psel & ~penable;
  wire wr = setup & pwrite;
  wire hit_self = (paddr == ltdc_pkg::OFF_SELF_LINK);
  wire hit_rxd = (paddr == ltdc_pkg::OFF_RX_DET);
  wire hit_tx = (paddr == ltdc_pkg::OFF_TX_FORCE);
  wire hit_slow = (paddr == ltdc_pkg::OFF_SLOW_SCR);
  wire hit_fast = (paddr == ltdc_pkg::OFF_FAST_SCR);
  wire hit_bal = (paddr == ltdc_pkg::OFF_BALIGN);
  wire hit_sds = (paddr == ltdc_pkg::OFF_SDS_FLAGS);
  wire hit_any = hit_self | hit_rxd | hit_tx | hit_slow | hit_fast | hit_bal | hit_sds;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = ltdc_pkg::RST_VAL;
    if (hit_self) begin
      rd_mux[ltdc_pkg::B_EN] = self_r;
    end else if (hit_rxd) begin
      rd_mux[ltdc_pkg::B_BYPASS] = byp_r;
      rd_mux[ltdc_pkg::B_INHIBIT] = inh_r;
    end else if (hit_tx) begin
      rd_mux[ltdc_pkg::B_EMPH_ON] = emph_on_r;
      rd_mux[ltdc_pkg::B_EMPH_LVL] = emph_lvl_r;
      rd_mux[ltdc_pkg::B_MARGIN_EN] = marg_en_r;
      rd_mux[ltdc_pkg::B_MARGIN_HI:0] = marg_val_r;
    end else if (hit_slow) begin
      rd_mux[ltdc_pkg::B_EN] = slow_r;
    end else if (hit_fast) begin
      rd_mux[ltdc_pkg::B_EN] = fast_r;
    end else if (hit_bal) begin
      rd_mux[ltdc_pkg::B_ALG_SEL] = alg_r;
      rd_mux[ltdc_pkg::B_EXCL_HI:0] = skip_r;
    end else if (hit_sds) begin
      rd_mux[ltdc_pkg::LANES-1:0] = sds_flags;
    end
  end
  assign sds_clr_stb = wr & hit_sds;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= ltdc_pkg::RST_VAL;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? ltdc_pkg::RST_VAL : rd_mux;
      pslverr_r <= ~hit_any;
    end else begin
      // error flag only in the access cycle
      pslverr_r <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_r <= 1'b0;
      byp_r <= 1'b0;
      inh_r <= 1'b0;
      emph_on_r <= 1'b0;
      emph_lvl_r <= 1'b0;
      marg_en_r <= 1'b0;
      marg_val_r <= 3'h0;
      slow_r <= 1'b0;
      fast_r <= 1'b0;
      alg_r <= 1'b0;
      skip_r <= 6'h00;
    end else if (wr) begin
      if (hit_self) self_r <= pwdata[ltdc_pkg::B_EN];
      if (hit_rxd) byp_r <= pwdata[ltdc_pkg::B_BYPASS];
      if (hit_rxd) inh_r <= pwdata[ltdc_pkg::B_INHIBIT];
      if (hit_tx) emph_on_r <= pwdata[ltdc_pkg::B_EMPH_ON];
      if (hit_tx) emph_lvl_r <= pwdata[ltdc_pkg::B_EMPH_LVL];
      if (hit_tx) marg_en_r <= pwdata[ltdc_pkg::B_MARGIN_EN];
      if (hit_tx) marg_val_r <= pwdata[ltdc_pkg::B_MARGIN_HI:0];
      if (hit_slow) slow_r <= pwdata[ltdc_pkg::B_EN];
      if (hit_fast) fast_r <= pwdata[ltdc_pkg::B_EN];
      if (hit_bal) alg_r <= pwdata[ltdc_pkg::B_ALG_SEL];
      if (hit_bal) skip_r <= pwdata[ltdc_pkg::B_EXCL_HI:0];
    end
  end
  assign ctl.self_link = self_r;
  assign ctl.rxdet_bypass = byp_r;
  assign ctl.rxdet_inhibit = inh_r;
  assign ctl.emph_on = emph_on_r;
  assign ctl.emph_level = emph_lvl_r;
  assign ctl.margin_en = marg_en_r;
  assign ctl.margin_val = marg_val_r;
  assign ctl.slow_scr_off = slow_r;
  assign ctl.fast_scr_off = fast_r;
  assign ctl.alg_sel = alg_r;
  assign ctl.skip_mask = skip_r;
endmodule

// ===== ltdc_top.sv
// link training debug controls: apb slave and phy-facing overrides
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module ltdc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ltdc_pkg::LANES-1:0] sds_seen,
  input wire logic [1:0] link_rate,
  input wire logic mid_rate_capable,
  input wire logic [3:0] ltssm_state,
  input wire logic cfg_rx_exit_met,
  input wire logic rec_rx_exit_met,
  input wire logic [ltdc_pkg::LANES-1:0] rxdet_result,
  input wire logic proto_tx_deemph,
  input wire logic [2:0] proto_tx_margin,
  input wire logic rx_data_align_hint,
  output logic [ltdc_pkg::LANES-1:0] rx_present_r,
  output logic self_link_mode_r,
  output logic tx_deemph_r,
  output logic [2:0] tx_margin_r,
  output logic slow_scramble_off_r,
  output logic fast_scramble_off_r,
  output logic block_align_r
);
  ltdc_ctl_if ctl ();
  logic [ltdc_pkg::LANES-1:0] flags;
  logic clr_stb;
  logic [31:0] prdata_q;
  logic pslverr_q;
  ltdc_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .sds_flags(flags),
    .prdata_r(prdata_q),
    .pslverr_r(pslverr_q),
    .sds_clr_stb(clr_stb),
    .ctl(ctl)
  );
  ltdc_sds_flags u_sds (
    .pclk(pclk),
    .presetn(presetn),
    .sds_seen(sds_seen),
    .rate(link_rate),
    .clr_stb(clr_stb),
    .clr_bits(pwdata[ltdc_pkg::LANES-1:0]),
    .flags_r(flags)
  );
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  // no wait states: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end
  ltdc_pkg::ltdc_ltssm_t st;
  assign st = ltdc_pkg::ltdc_ltssm_t'(ltssm_state);
  logic [ltdc_pkg::LANES-1:0] present_nxt;
  assign present_nxt = ctl.rxdet_bypass ? {ltdc_pkg::LANES{1'b1}} :
    ctl.rxdet_inhibit ? {ltdc_pkg::LANES{1'b0}} : rxdet_result;
  wire force_emph = ctl.emph_on & mid_rate_capable & (link_rate == ltdc_pkg::RATE_5G)
    & (st != ltdc_pkg::LTDC_ST_POLL_COMPLIANCE);
  logic deemph_nxt;
  assign deemph_nxt = force_emph ? ctl.emph_level : proto_tx_deemph;
  logic [2:0] margin_nxt;
  assign margin_nxt = ctl.margin_en ? ctl.margin_val : proto_tx_margin;
  logic slow_nxt;
  assign slow_nxt = ctl.slow_scr_off & (st == ltdc_pkg::LTDC_ST_CFG_COMPLETE)
    & ((link_rate == ltdc_pkg::RATE_2G5) | (link_rate == ltdc_pkg::RATE_5G));
  wire fast_rate = (link_rate == ltdc_pkg::RATE_8G) | (link_rate == ltdc_pkg::RATE_16G);
  logic [5:0] low_st;
  always_comb begin
    low_st = 6'h00;
    case (st)
      ltdc_pkg::LTDC_ST_L0: low_st[ltdc_pkg::X_L0] = 1'b1;
      ltdc_pkg::LTDC_ST_TX_L0S: low_st[ltdc_pkg::X_L0] = 1'b1;
      ltdc_pkg::LTDC_ST_REC_IDLE: low_st[ltdc_pkg::X_REC_IDLE] = 1'b1;
      ltdc_pkg::LTDC_ST_REC_RCVR_CFG: low_st[ltdc_pkg::X_REC_RCVR_CFG] = rec_rx_exit_met;
      ltdc_pkg::LTDC_ST_CFG_IDLE: low_st[ltdc_pkg::X_CFG_IDLE] = 1'b1;
      ltdc_pkg::LTDC_ST_CFG_COMPLETE: low_st[ltdc_pkg::X_CFG_COMPLETE] = cfg_rx_exit_met;
      ltdc_pkg::LTDC_ST_LPBK_LEADER: low_st[ltdc_pkg::X_LPBK_LEADER] = 1'b1;
      default: low_st = 6'h00;
    endcase
  end
  wire drive_low = |(low_st & ~ctl.skip_mask);
  logic align_nxt;
  assign align_nxt = ctl.alg_sel ? ~drive_low : rx_data_align_hint;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_present_r <= {ltdc_pkg::LANES{1'b0}};
      self_link_mode_r <= 1'b0;
      tx_deemph_r <= 1'b0;
      tx_margin_r <= 3'h0;
      slow_scramble_off_r <= 1'b0;
      fast_scramble_off_r <= 1'b0;
      block_align_r <= 1'b0;
    end else begin
      rx_present_r <= present_nxt;
      self_link_mode_r <= ctl.self_link;
      tx_deemph_r <= deemph_nxt;
      tx_margin_r <= margin_nxt;
      slow_scramble_off_r <= slow_nxt;
      fast_scramble_off_r <= ctl.fast_scr_off & fast_rate;
      block_align_r <= align_nxt;
    end
  end
endmodule

// ===== ltdc_checker.sv
// assertion checker for the link training debug controls
`timescale 1ns/1ps
module ltdc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [1:0] link_rate,
  input wire logic mid_rate_capable,
  input wire logic [3:0] ltssm_state,
  input wire logic cfg_rx_exit_met,
  input wire logic rec_rx_exit_met,
  input wire logic [ltdc_pkg::LANES-1:0] rxdet_result,
  input wire logic proto_tx_deemph,
  input wire logic [2:0] proto_tx_margin,
  input wire logic rx_data_align_hint,
  input wire logic [ltdc_pkg::LANES-1:0] rx_present_r,
  input wire logic self_link_mode_r,
  input wire logic tx_deemph_r,
  input wire logic [2:0] tx_margin_r,
  input wire logic slow_scramble_off_r,
  input wire logic block_align_r
);
  logic [31:0] sh_r [6];
  logic up_r;
  wire [3:0] st = ltssm_state;
  wire [5:0] k = sh_r[5][5:0];
  wire wr = psel && !penable && pwrite && paddr[7:5] == 3'h6 && paddr[1:0] == 2'h0;
  wire [2:0] idx = paddr[4:2];
  wire [15:0] rx_exp = sh_r[1][0] ? 16'hFFFF : (sh_r[1][16] ? 16'h0000 : rxdet_result);
  wire sl_exp = sh_r[0][0];
  wire force_de = sh_r[2][9] && mid_rate_capable && link_rate == 2'h1 && st != 4'h2;
  wire de_exp = force_de ? sh_r[2][8] : proto_tx_deemph;
  wire [2:0] mg_exp = sh_r[2][3] ? sh_r[2][2:0] : proto_tx_margin;
  wire sc_exp = sh_r[3][0] && st == 4'h4 && !link_rate[1];
  wire low = (st == 4'hB && !k[5]) || (st == 4'h4 && !k[4] && cfg_rx_exit_met)
    || (st == 4'h5 && !k[3]) || (st == 4'h9 && !k[2] && rec_rx_exit_met)
    || (st == 4'hA && !k[1]) || ((st == 4'h6 || st == 4'h7) && !k[0]);
  wire al_exp = sh_r[5][31] ? !low : rx_data_align_hint;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r <= 1'b0;
      for (int i = 0; i < 6; i++)
        sh_r[i] <= 32'h0000_0000;
    end else begin
      up_r <= 1'b1;
      if (wr && idx < 3'h6)
        sh_r[idx] <= pwdata;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  answer_next_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  rx_present_a: assert property (up_r |=> rx_present_r == $past(rx_exp))
    else $error("receiver present mismatch");
  self_link_a: assert property (up_r |=> self_link_mode_r == $past(sl_exp))
    else $error("self link mismatch");
  emph_force_a: assert property (up_r |=> tx_deemph_r == $past(de_exp))
    else $error("deemphasis mismatch");
  margin_force_a: assert property (up_r |=> tx_margin_r == $past(mg_exp))
    else $error("margin mismatch");
  slow_scr_a: assert property (up_r |=> slow_scramble_off_r == $past(sc_exp))
    else $error("slow scramble mismatch");
  align_hint_a: assert property (up_r |=> block_align_r == $past(al_exp))
    else $error("alignment hint mismatch");
  cover property (sh_r[1][0] && sh_r[1][16]);
  cover property (sh_r[5][31] && st == 4'h4 && cfg_rx_exit_met);
  cover property (force_de && st == 4'h6);
endmodule
bind ltdc_top ltdc_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .link_rate, .mid_rate_capable, .ltssm_state, .cfg_rx_exit_met, .rec_rx_exit_met,
  .rxdet_result, .proto_tx_deemph, .proto_tx_margin, .rx_data_align_hint, .rx_present_r,
  .self_link_mode_r, .tx_deemph_r, .tx_margin_r, .slow_scramble_off_r, .block_align_r);

// ===== ltdc_phy_model.sv
// far-side phy lane model: sds receipt, receiver detect, align hint
`timescale 1ns/1ps
module ltdc_phy_model #(
  parameter logic [15:0] DET_PATTERN = 16'hA5C3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] sds_req,
  output logic [15:0] sds_seen,
  output logic [15:0] rxdet_result,
  output logic rx_data_align_hint
);
  assign rxdet_result = DET_PATTERN;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sds_seen <= 16'h0000;
      rx_data_align_hint <= 1'b0;
    end else begin
      sds_seen <= sds_req;
      rx_data_align_hint <= ~rx_data_align_hint;
    end
  end
endmodule

// ===== testbench.sv
// self-checking bench for the link training debug controls
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] sds_req, sds_seen, rxdet, rx_present;
  logic [1:0] rate;
  logic [3:0] st;
  logic [2:0] pmargin, margin;
  logic cap, cfg_ok, rec_ok, pdeemph, hint, self_link, deemph, slow_off, fast_off, balign;
  int n_mismatch, n_checks, cyc;
  logic [31:0] rxv [4] = '{32'h0, 32'h1_0000, 32'h1, 32'h1_0001};
  logic [15:0] rxe [4] = '{16'hA5C3, 16'h0000, 16'hFFFF, 16'hFFFF};
  logic [11:0] ec [5] = '{12'h6E0, 12'h6B1, 12'h2E1, 12'h661, 12'h6C1};
  logic [12:0] ac [12] = '{13'h0021, 13'h0024, 13'h0825, 13'h004A, 13'h0049, 13'h0030,
    13'h00B9, 13'h0058, 13'h1059, 13'h0028, 13'h0050, 13'h0001};
  logic [7:0] ra [6] = '{8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hD0, 8'hD4};
  logic [31:0] re [6] = '{32'h1, 32'h1_0001, 32'h30F, 32'h1, 32'h1, 32'h8000_003F};
  ltdc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sds_seen(sds_seen), .link_rate(rate), .mid_rate_capable(cap),
    .ltssm_state(st), .cfg_rx_exit_met(cfg_ok), .rec_rx_exit_met(rec_ok),
    .rxdet_result(rxdet), .proto_tx_deemph(pdeemph), .proto_tx_margin(pmargin),
    .rx_data_align_hint(hint), .rx_present_r(rx_present), .self_link_mode_r(self_link),
    .tx_deemph_r(deemph), .tx_margin_r(margin), .slow_scramble_off_r(slow_off),
    .fast_scramble_off_r(fast_off), .block_align_r(balign));
  ltdc_phy_model #(.DET_PATTERN(16'hA5C3)) phy_u (.pclk(pclk), .presetn(presetn),
    .sds_req(sds_req), .sds_seen(sds_seen), .rxdet_result(rxdet), .rx_data_align_hint(hint));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, q);
  endtask
  task automatic tick();
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sds_req, rate, st} = '0;
    {pmargin, cap, cfg_ok, rec_ok, pdeemph} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 7; a++)
      rdchk(8'hC0 + 8'(a * 4), 32'h0000_0000);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'h0000_0000);
    `CHK("pslverr", 1'b1, err);
    foreach (rxv[i]) begin
      apb(1'b1, 8'hC4, rxv[i]);
      tick();
      `CHK("rx_present", rxe[i], rx_present);
    end
    apb(1'b1, 8'hC0, 32'h1);
    tick();
    `CHK("self_link", 1'b1, self_link);
    rate <= 2'h1;
    foreach (ec[i]) begin
      st <= ec[i][11:8];
      cap <= ec[i][7];
      pdeemph <= ec[i][6];
      apb(1'b1, 8'hC8, {22'h0, ec[i][5:4], 8'h00});
      tick();
      `CHK("tx_deemph", ec[i][0], deemph);
    end
    pmargin <= 3'h2;
    apb(1'b1, 8'hC8, 32'h0F);
    tick();
    `CHK("tx_margin", 3'h7, margin);
    apb(1'b1, 8'hC8, 32'h05);
    tick();
    `CHK("tx_margin", 3'h2, margin);
    st <= 4'h4;
    rate <= 2'h0;
    apb(1'b1, 8'hCC, 32'h1);
    tick();
    `CHK("slow_scramble", 1'b1, slow_off);
    rate <= 2'h2;
    apb(1'b1, 8'hD0, 32'h1);
    tick();
    `CHK("slow_scramble", 1'b0, slow_off);
    `CHK("fast_scramble", 1'b1, fast_off);
    sds_req <= 16'h0008;
    fork
      apb(1'b1, 8'hD8, 32'h0000_0008);
      begin
        @(posedge pclk);
        sds_req <= 16'h0000;
      end
    join
    rdchk(8'hD8, 32'h0000_0008);
    apb(1'b1, 8'hD8, 32'h0000_0000);
    rdchk(8'hD8, 32'h0000_0008);
    apb(1'b1, 8'hD8, 32'h0000_0008);
    rdchk(8'hD8, 32'h0000_0000);
    rate <= 2'h3;
    sds_req <= 16'h0020;
    tick();
    sds_req <= 16'h0000;
    rdchk(8'hD8, 32'h0000_0000);
    rate <= 2'h2;
    sds_req <= 16'h8020;
    tick();
    sds_req <= 16'h0000;
    rdchk(8'hD8, 32'h0000_8020);
    foreach (ac[i]) begin
      st <= ac[i][6:3];
      cfg_ok <= ac[i][2];
      rec_ok <= ac[i][1];
      apb(1'b1, 8'hD4, {1'b1, 25'h0, ac[i][12:7]});
      tick();
      `CHK("block_align", ac[i][0], balign);
    end
    apb(1'b1, 8'hD4, 32'h0000_0000);
    tick();
    `CHK("block_align", ~hint, balign);
    foreach (ra[i]) begin
      apb(1'b1, ra[i], 32'hFFFF_FFFF);
      rdchk(ra[i], re[i]);
    end
    close_out();
  end
endmodule
